// [pmc_defines.svh]
// Constants for the power-management configuration block: offsets, fields, timing.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ========
// Clock and timing
`define PMC_CLK_MHZ 20
`define PMC_TICK_US 500
`define PMC_TICK_CYCLES (`PMC_TICK_US * `PMC_CLK_MHZ)
`define PMC_SOFT_SMI_TIMER_LONG_US 64000
`define PMC_SOFT_SMI_TIMER_SHORT_US 1500
`define PMC_SOFT_SMI_TIMER_LONG_TICKS (`PMC_SOFT_SMI_TIMER_LONG_US / `PMC_TICK_US)
`define PMC_SOFT_SMI_TIMER_SHORT_TICKS (`PMC_SOFT_SMI_TIMER_SHORT_US / `PMC_TICK_US)
`define PMC_US_PER_S 1000000
`define PMC_PER_SEL0_S 60
`define PMC_PER_SEL1_S 32
`define PMC_PER_SEL2_S 16
`define PMC_PER_SEL3_S 8
`define PMC_S_TO_TICKS(s) (((s) * `PMC_US_PER_S) / `PMC_TICK_US)
`define PMC_TIMER_W 17

// ========
// Register word indices (byte address is four times the index)
`define PMC_IDX_CFG 3'h0
`define PMC_IDX_FSCTRL 3'h1
`define PMC_IDX_STATUS 3'h2
`define PMC_IDX_CLEAR 3'h3
`define PMC_IDX_ENABLE 3'h4
`define PMC_IDX_CTRL 3'h5

// ========
// Configuration register fields
`define PMC_CFG_W 11
`define PMC_CFG_RESET 11'h000
`define PMC_CFG_WMASK_DESK 11'h463
`define PMC_CFG_WMASK_MOB 11'h46f
`define PMC_CFG_SOFT_RATE 10
`define PMC_CFG_PWR_LEVEL 9
`define PMC_CFG_WIDE_CPU 6
`define PMC_CFG_SLEEP_ALLOW 5
`define PMC_CFG_FS_EN 3
`define PMC_CFG_PCI_CLOCK_RUN_ENABLE 2
`define PMC_CFG_PER_MSB 1
`define PMC_CFG_PER_LSB 0

// ========
// Event, control and reset values
`define PMC_EV_W 2
`define PMC_EV_SOFT 0
`define PMC_EV_PER 1
`define PMC_CTRL_SLEEP_CMD 0
`define PMC_CTRL_SOFT_START 1
`define PMC_FS_W 8
`define PMC_FS_RESET 8'h00

`endif

// [pmc_pkg.sv]
// Types shared by the power-management configuration block.
package pmc_pkg;

    // ========
    // Bus handshake states
    typedef enum logic [1:0] {
        PMC_BUS_IDLE = 2'b01,
        PMC_BUS_ACK = 2'b10
    } pmc_bus_state_type;

    // ========
    // Whole state of the top module
    typedef struct packed {
        pmc_bus_state_type busState;
        logic waitreq;
        logic [31:0] rdata;
        logic [10:0] cfg;
        logic [7:0] fsCtrl;
        logic sleepCmd;
        logic softStart;
        logic perArmed;
        logic [1:0] status;
        logic [1:0] irqEnable;
        logic irq;
        logic pwrLevel;
        logic cpuSleepN;
        logic clkRunOut;
        logic clkRunOe;
        logic pciClockStop;
        logic [7:0] fsOut;
        logic softSmi;
        logic perSmi;
    } pmc_top_state_type;

endpackage : pmc_pkg

// [pmc_tick_div.sv]
// Divider that turns the core clock into a one-cycle timebase tick.
`timescale 1ns/1ps
`default_nettype none

module pmc_tick_div #(
    parameter int unsigned CYCLES = 10000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Timebase
    output logic tick
);
    localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

    typedef struct packed {
        logic [W-1:0] count;
        logic tick;
    } pmc_div_state_type;

    pmc_div_state_type q;
    pmc_div_state_type d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.count == W'(CYCLES - 1)) begin
            d.count = '0;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule : pmc_tick_div

`default_nettype wire

// [pmc_interval_timer.sv]
// Down-counting interval timer clocked by the timebase tick.
`timescale 1ns/1ps
`default_nettype none

module pmc_interval_timer #(
    parameter int unsigned WIDTH = 17,
    parameter bit AUTO_RELOAD = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic tick,
    input wire logic start,
    input wire logic [WIDTH-1:0] loadValue,
    // Result
    output logic expired,
    output logic running
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic running;
        logic expired;
    } pmc_timer_state_type;

    pmc_timer_state_type q;
    pmc_timer_state_type d;

    always_comb begin
        d = q;
        d.expired = 1'b0;
        if (start) begin
            d.count = loadValue;
            d.running = 1'b1;
        end else if (q.running && tick) begin
            if (q.count <= WIDTH'(1)) begin
                d.expired = 1'b1;
                // Reload samples the select only here, never mid-count
                d.count = loadValue;
                d.running = AUTO_RELOAD;
            end else begin
                d.count = q.count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.expired;
    assign running = q.running;

endmodule : pmc_interval_timer

`default_nettype wire

// [pmc_config_low.sv]
// Top of the power-management configuration block with its Avalon-MM slave.
//
// How it works
// - Bit 10 picks 64 ms or 1.5 ms
// - Bit 9 reads power button pin level
// - Bit 6 flags a wide processor mode
// - Desktop: allow bit lets sleep out in S1
// - Desktop: sleep out on S3, S4, S5 always
// - Mobile: allow bit lets sleep out in C3
// - Mobile: sleep out on transitions, S1..S5 always
// - Mobile bit 3 gates frequency switch register
// - Mobile bit 2 clear drives clock run low
// - Mobile: sleep command forces clock run low
// - Bits 1:0 choose periodic SMI interval
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`include "pmc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pmc_config_low
    import pmc_pkg::*;
#(
    parameter bit MOBILE_VARIANT = 1'b1,
    parameter int unsigned TICK_CYCLES = `PMC_TICK_CYCLES,
    parameter int unsigned PER_SEL0_TICKS = `PMC_S_TO_TICKS(`PMC_PER_SEL0_S),
    parameter int unsigned PER_SEL1_TICKS = `PMC_S_TO_TICKS(`PMC_PER_SEL1_S),
    parameter int unsigned PER_SEL2_TICKS = `PMC_S_TO_TICKS(`PMC_PER_SEL2_S),
    parameter int unsigned PER_SEL3_TICKS = `PMC_S_TO_TICKS(`PMC_PER_SEL3_S)
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt
    output logic irq,
    // Power button pin, active low level
    input wire logic powerButtonPinN,
    // Power state from the sleep sequencer
    input wire logic stateS1,
    input wire logic stateDeepSleep,
    input wire logic cpuStateC3,
    input wire logic freqSwitchBusy,
    // Processor sleep pin, active low
    output logic cpuSleepOutN,
    // PCI clock run pin, open drain
    input wire logic clockRunInN,
    output logic clockRunOutN,
    output logic clockRunOe,
    output logic pciClockStopOutN,
    // Frequency switching control seen by its logic
    output logic [7:0] freqSwitchControl,
    // SMI timer expiry events
    output logic softSmiTimerExpired,
    output logic periodicSmiExpired
);

    // ========
    // Constants
    localparam logic [`PMC_TIMER_W-1:0] SOFT_LONG = `PMC_TIMER_W'(`PMC_SOFT_SMI_TIMER_LONG_TICKS);
    localparam logic [`PMC_TIMER_W-1:0] SOFT_SHORT = `PMC_TIMER_W'(`PMC_SOFT_SMI_TIMER_SHORT_TICKS);
    localparam logic [`PMC_TIMER_W-1:0] PER0 = `PMC_TIMER_W'(PER_SEL0_TICKS);
    localparam logic [`PMC_TIMER_W-1:0] PER1 = `PMC_TIMER_W'(PER_SEL1_TICKS);
    localparam logic [`PMC_TIMER_W-1:0] PER2 = `PMC_TIMER_W'(PER_SEL2_TICKS);
    localparam logic [`PMC_TIMER_W-1:0] PER3 = `PMC_TIMER_W'(PER_SEL3_TICKS);
    localparam logic [`PMC_CFG_W-1:0] CFG_WMASK =
        MOBILE_VARIANT ? `PMC_CFG_WMASK_MOB : `PMC_CFG_WMASK_DESK;

    // ========
    // Functions
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldValue,
        input logic [31:0] newValue,
        input logic [3:0] enables
    );
        logic [31:0] result;
        result = oldValue;
        for (int i = 0; i < 4; i++) begin
            if (enables[i]) begin
                result[i*8 +: 8] = newValue[i*8 +: 8];
            end
        end
        return result;
    endfunction : mergeBytes

    function automatic logic [`PMC_TIMER_W-1:0] perLoad(input logic [1:0] sel);
        logic [`PMC_TIMER_W-1:0] value;
        value = PER0;
        case (sel)
            2'h0: value = PER0;
            2'h1: value = PER1;
            2'h2: value = PER2;
            2'h3: value = PER3;
            default: value = PER0;
        endcase
        return value;
    endfunction : perLoad

    // ========
    // State and timers
    pmc_top_state_type q;
    pmc_top_state_type d;
    logic tick;
    logic softExpired;
    logic perExpired;
    logic [`PMC_TIMER_W-1:0] softLoad;
    logic [`PMC_TIMER_W-1:0] perLoadValue;

    // Long period while bit 10 is clear; short one while it is set
    assign softLoad = q.cfg[`PMC_CFG_SOFT_RATE] ? SOFT_SHORT : SOFT_LONG;
    assign perLoadValue = perLoad(q.cfg[`PMC_CFG_PER_MSB:`PMC_CFG_PER_LSB]);

    pmc_tick_div #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick)
    );

    // One-shot; a new start restarts the count at the current rate
    pmc_interval_timer #(
        .WIDTH(`PMC_TIMER_W),
        .AUTO_RELOAD(1'b0)
    ) u_soft_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .start(q.softStart),
        .loadValue(softLoad),
        .expired(softExpired),
        .running()
    );

    // Free running from reset release, reloads itself at each expiry
    pmc_interval_timer #(
        .WIDTH(`PMC_TIMER_W),
        .AUTO_RELOAD(1'b1)
    ) u_per_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .start(!q.perArmed),
        .loadValue(perLoadValue),
        .expired(perExpired),
        .running()
    );

    // ========
    // Next state
    always_comb begin
        logic [31:0] readValue;
        logic [31:0] merged;
        logic [`PMC_CFG_W-1:0] cfgView;
        logic [`PMC_EV_W-1:0] clearMask;
        logic [`PMC_EV_W-1:0] events;
        logic fsEnabled;
        logic sleepAssert;

        readValue = 32'h0000_0000;
        merged = 32'h0000_0000;
        clearMask = '0;
        events = '0;
        sleepAssert = 1'b0;
        d = q;
        d.softStart = 1'b0;
        d.perArmed = 1'b1;

        // Reserved and variant-absent bits never stored, always read zero
        cfgView = q.cfg & CFG_WMASK;
        cfgView[`PMC_CFG_PWR_LEVEL] = q.pwrLevel;
        fsEnabled = MOBILE_VARIANT && q.cfg[`PMC_CFG_FS_EN];

        case (address[4:2])
            `PMC_IDX_CFG: readValue = {21'h00_0000, cfgView};
            `PMC_IDX_FSCTRL: readValue = fsEnabled ? {24'h00_0000, q.fsCtrl} : 32'h0000_0000;
            `PMC_IDX_STATUS: readValue = {30'h0000_0000, q.status};
            `PMC_IDX_ENABLE: readValue = {30'h0000_0000, q.irqEnable};
            `PMC_IDX_CTRL: readValue = {31'h0000_0000, q.sleepCmd};
            default: readValue = 32'h0000_0000;
        endcase

        // --------
        // Bus handshake: one wait cycle, write lands on the released edge
        case (q.busState)
            PMC_BUS_IDLE: begin
                d.waitreq = 1'b1;
                if (read || write) begin
                    d.busState = PMC_BUS_ACK;
                    d.waitreq = 1'b0;
                    d.rdata = read ? readValue : 32'h0000_0000;
                end
            end
            PMC_BUS_ACK: begin
                d.busState = PMC_BUS_IDLE;
                d.waitreq = 1'b1;
                if (write) begin
                    case (address[4:2])
                        `PMC_IDX_CFG: begin
                            merged = mergeBytes({21'h00_0000, q.cfg}, writedata, byteenable);
                            // Mode flag, allow bit and selects are plain storage
                            d.cfg = merged[`PMC_CFG_W-1:0] & CFG_WMASK;
                        end
                        `PMC_IDX_FSCTRL: begin
                            merged = mergeBytes({24'h00_0000, q.fsCtrl}, writedata, byteenable);
                            if (fsEnabled) begin
                                d.fsCtrl = merged[`PMC_FS_W-1:0];
                            end
                        end
                        `PMC_IDX_CLEAR: begin
                            merged = mergeBytes(32'h0000_0000, writedata, byteenable);
                            clearMask = merged[`PMC_EV_W-1:0];
                        end
                        `PMC_IDX_ENABLE: begin
                            merged = mergeBytes({30'h0000_0000, q.irqEnable}, writedata, byteenable);
                            d.irqEnable = merged[`PMC_EV_W-1:0];
                        end
                        `PMC_IDX_CTRL: begin
                            merged = mergeBytes({31'h0000_0000, q.sleepCmd}, writedata, byteenable);
                            d.sleepCmd = merged[`PMC_CTRL_SLEEP_CMD];
                            d.softStart = merged[`PMC_CTRL_SOFT_START];
                        end
                        default: begin
                            merged = 32'h0000_0000;
                        end
                    endcase
                end
            end
            default: begin
                d.busState = PMC_BUS_IDLE;
                d.waitreq = 1'b1;
            end
        endcase

        // --------
        // Events: a set in the clearing cycle survives
        events[`PMC_EV_SOFT] = softExpired;
        events[`PMC_EV_PER] = perExpired;
        d.status = (q.status & ~clearMask) | events;
        d.irq = |(d.status & d.irqEnable);
        d.softSmi = softExpired;
        d.perSmi = perExpired;

        // --------
        // Pins
        d.pwrLevel = powerButtonPinN;
        d.fsOut = fsEnabled ? q.fsCtrl : `PMC_FS_RESET;

        if (MOBILE_VARIANT) begin
            sleepAssert = (q.cfg[`PMC_CFG_SLEEP_ALLOW] && cpuStateC3)
                || freqSwitchBusy || stateS1 || stateDeepSleep;
        end else begin
            sleepAssert = (q.cfg[`PMC_CFG_SLEEP_ALLOW] && stateS1)
                || stateDeepSleep;
        end
        d.cpuSleepN = !sleepAssert;

        if (!MOBILE_VARIANT) begin
            d.clkRunOut = 1'b0;
            d.clkRunOe = 1'b0;
            d.pciClockStop = 1'b1;
        end else if (q.sleepCmd || !q.cfg[`PMC_CFG_PCI_CLOCK_RUN_ENABLE]) begin
            // Holding the line low keeps PCI and LPC clocks alive into sleep
            d.clkRunOut = 1'b0;
            d.clkRunOe = 1'b1;
            d.pciClockStop = 1'b1;
        end else begin
            // Released line means no agent needs the clock: stop it
            d.clkRunOut = 1'b0;
            d.clkRunOe = 1'b0;
            d.pciClockStop = !clockRunInN;
        end
    end

    // ========
    // Registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
            q.busState <= PMC_BUS_IDLE;
            q.waitreq <= 1'b1;
            q.cfg <= `PMC_CFG_RESET;
            q.fsCtrl <= `PMC_FS_RESET;
            q.cpuSleepN <= 1'b1;
            q.pciClockStop <= 1'b1;
            q.pwrLevel <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ========
    // Outputs
    assign readdata = q.rdata;
    assign waitrequest = q.waitreq;
    assign irq = q.irq;
    assign cpuSleepOutN = q.cpuSleepN;
    assign clockRunOutN = q.clkRunOut;
    assign clockRunOe = q.clkRunOe;
    assign pciClockStopOutN = q.pciClockStop;
    assign freqSwitchControl = q.fsOut;
    assign softSmiTimerExpired = q.softSmi;
    assign periodicSmiExpired = q.perSmi;

endmodule : pmc_config_low

`default_nettype wire

// [pmc_config_low_sva.sv]
// Checker for the power-management configuration block, bound to its top.
`timescale 1ns/1ps
`default_nettype none

module pmc_config_low_sva
    import pmc_pkg::*;
#(
    parameter bit MOBILE_VARIANT = 1'b1,
    parameter int unsigned TICK_CYCLES = 4,
    parameter int unsigned PER_SEL3_TICKS = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic irq,
    // Power state and pins
    input wire logic stateS1,
    input wire logic stateDeepSleep,
    input wire logic cpuStateC3,
    input wire logic freqSwitchBusy,
    input wire logic cpuSleepOutN,
    input wire logic clockRunOutN,
    input wire logic clockRunOe,
    // Timer events
    input wire logic softSmiTimerExpired,
    input wire logic periodicSmiExpired
);
    localparam logic [31:0] CFG_USED = MOBILE_VARIANT ? 32'h0000_066f : 32'h0000_0663;
    localparam int unsigned MIN_GAP = PER_SEL3_TICKS * TICK_CYCLES;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ========
    // Cycles since last periodic expiry
    logic [31:0] perGap_q;
    logic perSeen_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            perGap_q <= 32'h0000_0000;
            perSeen_q <= 1'b0;
        end else if (periodicSmiExpired) begin
            perGap_q <= 32'h0000_0001;
            perSeen_q <= 1'b1;
        end else begin
            perGap_q <= perGap_q + 32'h0000_0001;
        end
    end

    // ========
    // Assertions
    a_ack_next_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no ack after request");
    a_reserved_zero: assert property (read && waitrequest && address[4:2] == 3'h0 |=>
        (readdata & ~CFG_USED) == 32'h0000_0000)
        else $error("reserved bits nonzero");
    a_unmapped_zero: assert property (read && waitrequest && (address[4:2] == 3'h3 ||
        address[4:2] >= 3'h6) |=> readdata == 32'h0000_0000)
        else $error("unmapped read nonzero");
    a_deep_sleep_out: assert property (stateDeepSleep |=> !cpuSleepOutN)
        else $error("no sleep in deep sleep");
    a_mobile_forced_out: assert property (MOBILE_VARIANT && (stateS1 || freqSwitchBusy)
        |=> !cpuSleepOutN)
        else $error("no forced mobile sleep");
    a_idle_no_sleep: assert property (!(stateS1 || stateDeepSleep || cpuStateC3 ||
        freqSwitchBusy) |=> cpuSleepOutN)
        else $error("sleep with no cause");
    a_pci_clock_run_signal_drive_low: assert property (clockRunOe |-> !clockRunOutN)
        else $error("clock run driven high");
    a_soft_one_cycle: assert property (softSmiTimerExpired |=> !softSmiTimerExpired)
        else $error("soft pulse too long");
    a_per_min_gap: assert property (periodicSmiExpired && perSeen_q |->
        perGap_q >= MIN_GAP)
        else $error("periodic gap too short");

    c_soft_pulse: cover property (softSmiTimerExpired);
    c_per_pulse: cover property (periodicSmiExpired && perSeen_q);
    c_irq_rise: cover property ($rose(irq));
    c_read_ack: cover property (read && !waitrequest);

endmodule : pmc_config_low_sva

bind pmc_config_low pmc_config_low_sva #(.MOBILE_VARIANT(MOBILE_VARIANT),
    .TICK_CYCLES(TICK_CYCLES), .PER_SEL3_TICKS(PER_SEL3_TICKS)) i_pmc_config_low_sva (
    .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .stateS1(stateS1),
    .stateDeepSleep(stateDeepSleep), .cpuStateC3(cpuStateC3), .freqSwitchBusy(freqSwitchBusy),
    .cpuSleepOutN(cpuSleepOutN), .clockRunOutN(clockRunOutN), .clockRunOe(clockRunOe),
    .softSmiTimerExpired(softSmiTimerExpired), .periodicSmiExpired(periodicSmiExpired));

`default_nettype wire

// [pmc_config_low_test.sv]
// Self-checking bench for the power-management configuration block.
`timescale 1ns/1ps
`default_nettype none

module pmc_config_low_test;
    import pmc_pkg::*;

    localparam int unsigned TCK = 4;
    localparam int PER_T [4] = '{40, 30, 20, 10};

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hf;
    logic powerButtonPinN = 1'b1;
    logic stateS1 = 1'b0;
    logic stateDeepSleep = 1'b0;
    logic cpuStateC3 = 1'b0;
    logic freqSwitchBusy = 1'b0;
    logic extRunN = 1'b1;
    wire clockRunInN;
    logic [31:0] readdata, dReaddata, rq, dq;
    logic waitrequest, irq, cpuSleepOutN, dCpuSleepN, clockRunOutN, clockRunOe;
    logic pciClockStopOutN, softSmiTimerExpired, periodicSmiExpired;
    logic [7:0] freqSwitchControl;
    int numErrors = 0;
    int checkCount = 0;

    // Open-drain line with pull-up
    assign clockRunInN = clockRunOe ? 1'b0 : extRunN;

    always #25 sys_clk = ~sys_clk;

    pmc_config_low #(.TICK_CYCLES(TCK), .PER_SEL0_TICKS(PER_T[0]), .PER_SEL1_TICKS(PER_T[1]),
        .PER_SEL2_TICKS(PER_T[2]), .PER_SEL3_TICKS(PER_T[3])) i_pmc_config_low (
        .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .powerButtonPinN(powerButtonPinN),
        .stateS1(stateS1), .stateDeepSleep(stateDeepSleep), .cpuStateC3(cpuStateC3),
        .freqSwitchBusy(freqSwitchBusy), .cpuSleepOutN(cpuSleepOutN),
        .clockRunInN(clockRunInN), .clockRunOutN(clockRunOutN), .clockRunOe(clockRunOe),
        .pciClockStopOutN(pciClockStopOutN), .freqSwitchControl(freqSwitchControl),
        .softSmiTimerExpired(softSmiTimerExpired), .periodicSmiExpired(periodicSmiExpired));

    // Desktop twin: only read data and sleep pin judged
    pmc_config_low #(.MOBILE_VARIANT(1'b0), .TICK_CYCLES(TCK)) i_pmc_config_low_desk (
        .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(dReaddata),
        .waitrequest(), .irq(), .powerButtonPinN(powerButtonPinN), .stateS1(stateS1),
        .stateDeepSleep(stateDeepSleep), .cpuStateC3(cpuStateC3),
        .freqSwitchBusy(freqSwitchBusy), .cpuSleepOutN(dCpuSleepN),
        .clockRunInN(clockRunInN), .clockRunOutN(), .clockRunOe(), .pciClockStopOutN(),
        .freqSwitchControl(), .softSmiTimerExpired(), .periodicSmiExpired());

    // ========
    // Helpers
    task automatic endSim();
        $display("Checks %0d mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : endSim

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Request held until waitrequest sampled low
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] d,
        input logic [3:0] be);
        address <= {idx, 2'b00};
        writedata <= d;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        rq = readdata;
        dq = dReaddata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, 4'hf);
    endtask : wr

    task automatic rd(input logic [2:0] idx);
        bus(1'b0, idx, 32'h0000_0000, 4'hf);
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge sys_clk);
    endtask : settle

    task automatic waitPulse(input bit per, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((per ? periodicSmiExpired : softSmiTimerExpired) !== 1'b1);
    endtask : waitPulse

    // ========
    // Scenarios
    task automatic testResetAndConfig();
        rd(3'h0);
        check("cfg reset", 32'h0000_0200, rq);
        check("pci_clock_run_signal oe reset", 1'b1, clockRunOe);
        wr(3'h0, 32'h0000_ffff);
        rd(3'h0);
        check("cfg mobile all", 32'h0000_066f, rq);
        check("cfg desk all", 32'h0000_0663, dq);
        powerButtonPinN <= 1'b0;
        settle();
        rd(3'h0);
        check("cfg pin low", 32'h0000_046f, rq);
        powerButtonPinN <= 1'b1;
        wr(3'h0, 32'h0000_0000);
        bus(1'b1, 3'h0, 32'h0000_ffff, 4'b0010);
        rd(3'h0);
        check("cfg lane one", 32'h0000_0600, rq);
        rd(3'h7);
        check("unmapped", 32'h0000_0000, rq);
    endtask : testResetAndConfig

    task automatic testFreqSwitch();
        wr(3'h1, 32'h0000_00a5);
        rd(3'h1);
        check("fs hidden", 32'h0000_0000, rq);
        wr(3'h0, 32'h0000_0008);
        rd(3'h1);
        check("fs write ignored", 32'h0000_0000, rq);
        wr(3'h1, 32'h0000_005a);
        rd(3'h1);
        check("fs visible", 32'h0000_005a, rq);
        check("fs out", 8'h5a, freqSwitchControl);
        wr(3'h0, 32'h0000_0000);
        rd(3'h1);
        check("fs hidden again", 32'h0000_0000, rq);
        settle();
        check("fs out hidden", 8'h00, freqSwitchControl);
    endtask : testFreqSwitch

    task automatic testClockRun();
        wr(3'h0, 32'h0000_0004);
        settle();
        check("pci_clock_run_signal released", 1'b0, clockRunOe);
        check("pci stop", 1'b0, pciClockStopOutN);
        extRunN <= 1'b0;
        settle();
        check("pci run", 1'b1, pciClockStopOutN);
        extRunN <= 1'b1;
        wr(3'h5, 32'h0000_0001);
        settle();
        check("pci_clock_run_signal sleep cmd", 1'b1, clockRunOe);
        check("pci_clock_run_signal low", 1'b0, clockRunOutN);
        rd(3'h5);
        check("ctrl readback", 1'b1, rq);
        wr(3'h5, 32'h0000_0000);
        wr(3'h0, 32'h0000_0000);
        settle();
        check("pci_clock_run_signal disabled", 1'b1, clockRunOe);
    endtask : testClockRun

    task automatic testCpuSleep();
        for (int a = 0; a < 2; a++) begin
            wr(3'h0, 32'(a) << 5);
            for (int i = 0; i < 4; i++) begin
                {stateS1, stateDeepSleep, cpuStateC3, freqSwitchBusy} <= 4'b1000 >> i;
                settle();
                check("mobile sleep", (i == 2) ? a == 0 : 1'b0, cpuSleepOutN);
                if (i < 3) begin
                    check("desk sleep", (i == 0) ? a == 0 : i == 2, dCpuSleepN);
                end
            end
            {stateS1, stateDeepSleep, cpuStateC3, freqSwitchBusy} <= 4'b0000;
            settle();
            check("no sleep", 1'b1, cpuSleepOutN);
        end
    endtask : testCpuSleep

    task automatic testTimers();
        int n;
        wr(3'h4, 32'h0000_0001);
        wr(3'h0, 32'h0000_0400);
        wr(3'h5, 32'h0000_0002);
        waitPulse(1'b0, n);
        check("soft short", 1'b1, n >= 2 * TCK - 1 && n <= 3 * TCK + 3);
        settle();
        check("irq soft", 1'b1, irq);
        wr(3'h4, 32'h0000_0000);
        settle();
        check("irq masked", 1'b0, irq);
        rd(3'h2);
        check("status soft", 1'b1, rq[0]);
        wr(3'h4, 32'h0000_0001);
        wr(3'h3, 32'h0000_0001);
        settle();
        check("irq cleared", 1'b0, irq);
        wr(3'h0, 32'h0000_0000);
        wr(3'h5, 32'h0000_0002);
        waitPulse(1'b0, n);
        check("soft long", 1'b1, n >= 127 * TCK - 1 && n <= 128 * TCK + 3);
        wr(3'h3, 32'h0000_0001);
        wr(3'h4, 32'h0000_0002);
        for (int s = 0; s < 4; s++) begin
            wr(3'h0, 32'(s));
            // First gap may still run at the old rate
            repeat (3) waitPulse(1'b1, n);
            check("periodic gap", 32'(PER_T[s] * TCK), 32'(n));
        end
        settle();
        check("irq periodic", 1'b1, irq);
        wr(3'h3, 32'h0000_0002);
        settle();
        check("irq periodic cleared", 1'b0, irq);
    endtask : testTimers

    // ========
    // Main sequence and watchdog
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        testResetAndConfig();
        testFreqSwitch();
        testClockRun();
        testCpuSleep();
        testTimers();
        endSim();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        numErrors++;
        $display("MISMATCH watchdog expected done seen hang");
        endSim();
    end

endmodule : pmc_config_low_test

`default_nettype wire
